// file: hw/usm_uart.sv
// Function
// - mode 0 makes clock; mode 1 full-duplex
// - data read gives receive buffer, write transmits
// - receive shifter separate from readable buffer
// - idle pins follow port direction, level bits
// - mode 0 master: clock out, data LSB first
// - mode 0 clock is system/12 or /4
// - mode 0 data write sends eight bits
// - mode 0 data set before falling edge
// - mode 0 receive needs enable, flag clear
// - mode 0 latch on rising edges, set flag
// - mode 1 frame: start, eight data, stop
// - mode 1 send five cycles after bit tick
// - mode 1 sets transmit flag at stop bit
// - mode 1 falling edge starts receive
// - stop middle: accept when flag clear, check ok
// - rejected word leaves buffer, flag untouched
// - after stop middle, watch for falling edge
// - samples at counts 7,8,9, majority vote
// - start bit voting one abandons reception
// - baud pulses divided by sixteen per bit
// - phase added every clock or every fourth
`timescale 1ns/1ps
module usm_uart
	import usm_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              resetn,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	output logic                   txd_out,
	output logic                   txd_oe,
	input  wire logic              rxd_in,
	output logic                   rxd_out,
	output logic                   rxd_oe
);
	usm_baud_if bif ();

	logic [7:0]  ctrl_q;
	logic [3:0]  port_q;
	logic [15:0] phase_q;
	logic [7:0]  rx_buf_q;
	logic [15:0] rdata_q;
	logic        rxs1_q, rxs2_q, rxs3_q, rxf_q, rxprev_q;
	usm_m0_e     m0_st_q;
	logic [3:0]  m0_div_q, m0_cnt_q;
	logic [7:0]  m0_sh_q;
	logic        m0_clk_q, m0_dat_q;
	logic [3:0]  div16_q;
	usm_tx_e     tx_st_q;
	logic [7:0]  tx_buf_q;
	logic [9:0]  tx_fr_q;
	logic [3:0]  tx_cnt_q, tx_idx_q;
	logic [2:0]  dly_q;
	usm_rx_e     rx_st_q;
	logic [3:0]  rx_cnt_q, rx_idx_q;
	logic [7:0]  rx_sh_q;
	logic        txo_q, txe_q, rxo_q, rxe_q;
	logic        mode1, wr_ctrl, wr_data, m0_half, m0_rise, bit_tick, fall, vote, smp_en;
	logic        m0_rx_go, m0_done, rx_eval, rx_ok, ti_set, ri_set, tx_stop_enter, rx_acc;

	assign mode1   = ctrl_q[CTRL_MODE];
	assign wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
	assign wr_data = reg_wr && (reg_addr == REG_DATA);

	////////////////////////////////////////////////////////////////////////
	// baud generator and sample voter
	assign bif.phase       = phase_q;
	assign bif.rate_double = ctrl_q[CTRL_DOUBLE];

	usm_baud u_baud (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.bif     (bif.gen)
	);

	assign smp_en = (rx_st_q == R_BUSY) && bif.tick && (rx_cnt_q == SMP_FIRST || rx_cnt_q == SMP_MID);

	usm_vote u_vote (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.smp_en  (smp_en),
		.smp_in  (rxf_q),
		.maj     (vote)
	);

	////////////////////////////////////////////////////////////////////////
	// receive pin: three stages, change taken when stages 2 and 3 agree
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rxs1_q   <= 1'b1;
			rxs2_q   <= 1'b1;
			rxs3_q   <= 1'b1;
			rxf_q    <= 1'b1;
			rxprev_q <= 1'b1;
		end else begin
			rxs1_q   <= rxd_in;
			rxs2_q   <= rxs1_q;
			rxs3_q   <= rxs2_q;
			rxprev_q <= rxf_q;
			if (rxs2_q == rxs3_q) begin
				rxf_q <= rxs3_q;
			end
		end
	end

	assign fall = rxprev_q & ~rxf_q;

	////////////////////////////////////////////////////////////////////////
	// software registers; hardware setting a flag wins over a clear
	assign ti_set = (m0_done && m0_st_q == M0_TX) || tx_stop_enter;
	assign ri_set = (m0_done && m0_st_q == M0_RX) || rx_acc;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ctrl_q  <= CTRL_RST;
			port_q  <= PORT_RST;
			phase_q <= PHASE_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= reg_wdata[7:0];
			end
			if (reg_wr && reg_addr == REG_PORT) begin
				port_q <= reg_wdata[3:0];
			end
			if (reg_wr && reg_addr == REG_PHASE) begin
				phase_q <= reg_wdata;
			end
			if (ri_set) begin
				ctrl_q[CTRL_RXDONE] <= 1'b1;
			end
			if (ti_set) begin
				ctrl_q[CTRL_TXDONE] <= 1'b1;
			end
			if (rx_acc) begin
				ctrl_q[CTRL_EXTRA] <= vote;
			end
		end
	end

	// read data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				REG_CTRL:  rdata_q <= {8'h00, ctrl_q};
				REG_DATA:  rdata_q <= {8'h00, rx_buf_q};
				REG_PHASE: rdata_q <= phase_q;
				REG_PORT:  rdata_q <= {12'h000, port_q};
				default:   rdata_q <= 16'h0000;
			endcase
		end else begin
			rdata_q <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode 0 shift engine: half-period pulses from the system clock
	assign m0_half  = (m0_st_q != M0_IDLE) &&
	                  (m0_div_q == ((ctrl_q[CTRL_SEL] ? M0_DIV_FAST : M0_DIV_SLOW) >> 1) - 4'd1);
	assign m0_rise  = m0_half && !m0_clk_q;
	assign m0_done  = m0_rise && (m0_cnt_q == DATA_BITS - 4'd1);
	assign m0_rx_go = !mode1 && ctrl_q[CTRL_RXEN] && !ctrl_q[CTRL_RXDONE] && !wr_data;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			m0_st_q  <= M0_IDLE;
			m0_div_q <= 4'h0;
			m0_cnt_q <= 4'h0;
			m0_sh_q  <= 8'h00;
			m0_clk_q <= 1'b1;
			m0_dat_q <= 1'b1;
		end else begin
			unique case (m0_st_q)
				M0_IDLE: begin
					m0_div_q <= 4'h0;
					m0_cnt_q <= 4'h0;
					m0_clk_q <= 1'b1;
					if (!mode1 && wr_data) begin
						m0_st_q  <= M0_TX;
						m0_sh_q  <= reg_wdata[7:0];
						m0_dat_q <= reg_wdata[0];
					end else if (m0_rx_go) begin
						m0_st_q <= M0_RX;
					end
				end
				M0_TX, M0_RX: begin
					m0_div_q <= m0_half ? 4'h0 : m0_div_q + 4'h1;
					if (m0_half) begin
						m0_clk_q <= ~m0_clk_q;
					end
					if (m0_rise) begin
						m0_cnt_q <= m0_cnt_q + 4'h1;
						if (m0_st_q == M0_TX) begin
							m0_sh_q  <= {1'b0, m0_sh_q[7:1]};
							m0_dat_q <= m0_sh_q[1];
						end else begin
							m0_sh_q <= {rxf_q, m0_sh_q[7:1]};
						end
						if (m0_done) begin
							m0_st_q <= M0_IDLE;
						end
					end
				end
				default: m0_st_q <= M0_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// divide-by-16 of the baud pulse gives the bit tick
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			div16_q <= 4'h0;
		end else if (bif.tick) begin
			div16_q <= div16_q + 4'h1;
		end
	end

	assign bit_tick = bif.tick && (div16_q == OVS_LAST);

	////////////////////////////////////////////////////////////////////////
	// mode 1 transmitter; a write while busy is ignored
	assign tx_stop_enter = (tx_st_q == T_SEND) && bif.tick && (tx_cnt_q == OVS_LAST) &&
	                       (tx_idx_q == STOP_IDX - 4'd1);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tx_st_q  <= T_IDLE;
			tx_buf_q <= 8'h00;
			tx_fr_q  <= 10'h3ff;
			tx_cnt_q <= 4'h0;
			tx_idx_q <= 4'h0;
			dly_q    <= 3'h0;
		end else begin
			unique case (tx_st_q)
				T_IDLE: begin
					if (mode1 && wr_data) begin
						tx_buf_q <= reg_wdata[7:0];
						tx_st_q  <= T_WAIT;
					end
				end
				T_WAIT: begin
					if (bit_tick) begin
						tx_st_q <= T_DLY;
						dly_q   <= 3'h1;
					end
				end
				T_DLY: begin
					dly_q <= dly_q + 3'h1;
					if (dly_q == TX_START_DLY - 3'd1) begin
						tx_st_q  <= T_SEND;
						tx_fr_q  <= {1'b1, tx_buf_q, 1'b0};
						tx_cnt_q <= 4'h0;
						tx_idx_q <= 4'h0;
					end
				end
				T_SEND: begin
					if (bif.tick) begin
						tx_cnt_q <= tx_cnt_q + 4'h1;
						if (tx_cnt_q == OVS_LAST) begin
							tx_fr_q  <= {1'b1, tx_fr_q[9:1]};
							tx_idx_q <= tx_idx_q + 4'h1;
							if (tx_idx_q == STOP_IDX) begin
								tx_st_q <= T_IDLE;
							end
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode 1 receiver; runs beside the transmitter
	assign rx_eval = (rx_st_q == R_BUSY) && bif.tick && (rx_cnt_q == SMP_LAST);
	assign rx_ok   = !ctrl_q[CTRL_RXDONE] && (!ctrl_q[CTRL_SEL] || vote);
	// in mode 1 only the stop bit decision may load the buffer and raise the flag; mode 0 loads it at m0_done
	assign rx_acc  = rx_eval && (rx_idx_q == STOP_IDX) && rx_ok;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rx_st_q  <= R_IDLE;
			rx_cnt_q <= 4'h0;
			rx_idx_q <= 4'h0;
			rx_sh_q  <= 8'h00;
			rx_buf_q <= 8'h00;
		end else begin
			if (m0_done && m0_st_q == M0_RX) begin
				rx_buf_q <= {rxf_q, m0_sh_q[7:1]};
			end
			unique case (rx_st_q)
				R_IDLE: begin
					rx_cnt_q <= 4'h0;
					rx_idx_q <= 4'h0;
					if (mode1 && ctrl_q[CTRL_RXEN] && fall) begin
						rx_st_q <= R_BUSY;
					end
				end
				R_BUSY: begin
					if (bif.tick) begin
						rx_cnt_q <= rx_cnt_q + 4'h1;
						if (rx_cnt_q == OVS_LAST) begin
							rx_idx_q <= rx_idx_q + 4'h1;
						end
					end
					if (rx_eval) begin
						if (rx_idx_q == 4'h0 && vote) begin
							rx_st_q <= R_IDLE;
						end else if (rx_idx_q == STOP_IDX) begin
							rx_st_q <= R_IDLE;
							if (rx_ok) begin
								rx_buf_q <= rx_sh_q;
							end
						end else if (rx_idx_q != 4'h0) begin
							rx_sh_q <= {vote, rx_sh_q[7:1]};
						end
					end
					if (!mode1) begin
						rx_st_q <= R_IDLE;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drive; outside a character the port bits take over
	// shift clock pin takes the clock's next value, data pin lags a cycle: data holds past each rise
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			txo_q <= 1'b1;
			txe_q <= 1'b0;
			rxo_q <= 1'b1;
			rxe_q <= 1'b0;
		end else begin
			if (m0_st_q != M0_IDLE) begin
				txo_q <= m0_half ? ~m0_clk_q : m0_clk_q;
				txe_q <= 1'b1;
			end else if (tx_st_q == T_SEND) begin
				txo_q <= tx_fr_q[0];
				txe_q <= 1'b1;
			end else begin
				txo_q <= port_q[PORT_LVL_TX];
				txe_q <= port_q[PORT_DIR_TX];
			end
			if (m0_st_q == M0_TX) begin
				rxo_q <= m0_dat_q;
				rxe_q <= 1'b1;
			end else if (m0_st_q == M0_RX) begin
				rxo_q <= port_q[PORT_LVL_RX];
				rxe_q <= 1'b0;
			end else begin
				rxo_q <= port_q[PORT_LVL_RX];
				rxe_q <= port_q[PORT_DIR_RX];
			end
		end
	end

	assign reg_rdata = rdata_q;
	assign txd_out   = txo_q;
	assign txd_oe    = txe_q;
	assign rxd_out   = rxo_q;
	assign rxd_oe    = rxe_q;

	////////////////////////////////////////////////////////////////////////
	// checks
	a_read_rx_buf: assert property (@(posedge clk_sys) disable iff (!resetn)
		reg_rd && reg_addr == REG_DATA |=> rdata_q == {8'h00, $past(rx_buf_q)})
		else $error("data read did not return receive buffer");
	a_m0_tx_start: assert property (@(posedge clk_sys) disable iff (!resetn)
		m0_st_q == M0_IDLE && !mode1 && wr_data |=> m0_st_q == M0_TX ##1 txe_q)
		else $error("mode 0 write did not start sending");
	a_m0_rx_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
		m0_st_q == M0_IDLE && ctrl_q[CTRL_RXDONE] |=> m0_st_q != M0_RX)
		else $error("mode 0 receive started with flag set");
	a_flag_set_wins: assert property (@(posedge clk_sys) disable iff (!resetn)
		ri_set |=> ctrl_q[CTRL_RXDONE]) else $error("receive flag lost");
	a_tx_start_delay: assert property (@(posedge clk_sys) disable iff (!resetn)
		tx_st_q == T_WAIT && bit_tick |-> ##5 tx_st_q == T_SEND ##1 (txo_q == 1'b0))
		else $error("mode 1 start bit not five cycles after bit tick");
	a_ti_on_stop: assert property (@(posedge clk_sys) disable iff (!resetn)
		tx_stop_enter |=> ctrl_q[CTRL_TXDONE] && tx_idx_q == STOP_IDX)
		else $error("transmit flag not set at stop bit");
	a_start_abandon: assert property (@(posedge clk_sys) disable iff (!resetn)
		rx_eval && rx_idx_q == 4'h0 && vote |=> rx_st_q == R_IDLE)
		else $error("false start bit not abandoned");
	a_reject_keeps: assert property (@(posedge clk_sys) disable iff (!resetn)
		rx_eval && rx_idx_q == STOP_IDX && !rx_ok && m0_st_q == M0_IDLE |=> $stable(rx_buf_q))
		else $error("rejected word changed the buffer");
	a_pin_fallback: assert property (@(posedge clk_sys) disable iff (!resetn)
		m0_st_q == M0_IDLE && tx_st_q != T_SEND |=> txe_q == $past(port_q[PORT_DIR_TX]))
		else $error("idle transmit pin ignored port direction");
	a_rx_accept: assert property (@(posedge clk_sys) disable iff (!resetn)
		rx_acc |=> ctrl_q[CTRL_RXDONE] && rx_buf_q == $past(rx_sh_q))
		else $error("accepted word not loaded with flag");
	a_rx_no_early: assert property (@(posedge clk_sys) disable iff (!resetn)
		rx_eval && rx_idx_q != STOP_IDX && !ctrl_q[CTRL_RXDONE] && !wr_ctrl && mode1 |=> !ctrl_q[CTRL_RXDONE])
		else $error("receive flag set before the stop bit");
endmodule

// file: hw/usm_pkg.sv
package usm_pkg;

	// register bus
	localparam int         ADDR_W     = 3;
	localparam int         DATA_W     = 16;
	localparam logic [2:0] REG_CTRL   = 3'h0;
	localparam logic [2:0] REG_DATA   = 3'h1;
	localparam logic [2:0] REG_PHASE  = 3'h2;
	localparam logic [2:0] REG_PORT   = 3'h3;

	// serial_control_reg fields
	localparam int         CTRL_RXDONE = 0;
	localparam int         CTRL_TXDONE = 1;
	localparam int         CTRL_EXTRA  = 2;
	localparam int         CTRL_RXEN   = 4;
	localparam int         CTRL_SEL    = 5;
	localparam int         CTRL_MODE   = 6;
	localparam int         CTRL_DOUBLE = 7;
	localparam logic [7:0] CTRL_RST    = 8'h00;

	// port control fields: pin_direction_bits and pin_level_drive_bits
	localparam int         PORT_DIR_TX = 0;
	localparam int         PORT_DIR_RX = 1;
	localparam int         PORT_LVL_TX = 2;
	localparam int         PORT_LVL_RX = 3;
	localparam logic [3:0] PORT_RST    = 4'hc;
	localparam logic [15:0] PHASE_RST  = 16'h0000;

	// timing counts
	localparam logic [3:0] M0_DIV_SLOW  = 4'd12;
	localparam logic [3:0] M0_DIV_FAST  = 4'd4;
	localparam logic [1:0] BAUD_PRESCALE = 2'd3;
	localparam logic [3:0] OVS_LAST     = 4'd15;
	localparam logic [3:0] SMP_FIRST    = 4'd7;
	localparam logic [3:0] SMP_MID      = 4'd8;
	localparam logic [3:0] SMP_LAST     = 4'd9;
	localparam logic [2:0] TX_START_DLY = 3'd5;
	localparam logic [3:0] DATA_BITS    = 4'd8;
	localparam logic [3:0] STOP_IDX     = 4'd9;

	typedef enum logic [1:0] {M0_IDLE, M0_TX, M0_RX} usm_m0_e;
	typedef enum logic [1:0] {T_IDLE, T_WAIT, T_DLY, T_SEND} usm_tx_e;
	typedef enum logic       {R_IDLE, R_BUSY} usm_rx_e;

endpackage

// file: hw/usm_baud_if.sv
`timescale 1ns/1ps
// baud clock generator settings and its pulse output
interface usm_baud_if;
	logic [15:0] phase;
	logic        rate_double;
	logic        tick;
	modport gen  (input phase, input rate_double, output tick);
	modport user (output phase, output rate_double, input tick);
endinterface

// file: hw/usm_baud.sv
`timescale 1ns/1ps
module usm_baud
	import usm_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	usm_baud_if.gen  bif
);
	logic [1:0]  pre_q;
	logic [16:0] acc_q;
	logic [16:0] sum;
	logic        step;
	logic        tick_q;

	// step every clock when doubled, else every 4th clock
	assign step = bif.rate_double | (pre_q == BAUD_PRESCALE);
	assign sum  = {1'b0, acc_q[15:0]} + {1'b0, bif.phase};

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pre_q <= 2'h0;
		end else begin
			pre_q <= pre_q + 2'h1;
		end
	end

	// phase accumulator; carry out of bit 15 is the baud pulse
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			acc_q  <= 17'h00000;
			tick_q <= 1'b0;
		end else begin
			tick_q <= step & sum[16];
			if (step) begin
				acc_q <= {1'b0, sum[15:0]};
			end
		end
	end

	assign bif.tick = tick_q;

	a_baud_carry: assert property (@(posedge clk_sys) disable iff (!resetn)
		step && sum[16] |=> tick_q) else $error("baud carry gave no pulse");
endmodule

// file: hw/usm_vote.sv
`timescale 1ns/1ps
module usm_vote (
	input  wire logic clk_sys,
	input  wire logic resetn,
	input  wire logic smp_en,
	input  wire logic smp_in,
	output logic      maj
);
	logic [1:0] smp_q;

	// keep the first two samples; the third is the live input
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			smp_q <= 2'h0;
		end else if (smp_en) begin
			smp_q <= {smp_q[0], smp_in};
		end
	end

	// two of three decide the bit
	assign maj = (smp_q[1] & smp_q[0]) | (smp_q[1] & smp_in) | (smp_q[0] & smp_in);

	a_vote_majority: assert property (@(posedge clk_sys) disable iff (!resetn)
		(smp_q == 2'h3) |-> maj) else $error("two ones did not win the vote");
endmodule

// file: verif/usm_partner.sv
`timescale 1ns/1ps
// far-side serial device: mode 0 shift peripheral and mode 1 transceiver
module usm_partner #(
	parameter int BIT_NS = 1600
) (
	input  wire logic txd_line,
	input  wire logic rxd_line,
	input  wire logic rxd_oe,
	output logic      p_drv,
	output logic      p_val
);
	logic [7:0] m0_got;
	logic [7:0] m0_tx;
	logic       m0_arm;
	int         m0_i;
	int         m0_per;
	realtime    last_t;

	initial begin
		p_drv = 1'b0;
		p_val = 1'b1;
		m0_arm = 1'b0;
		m0_i = 0;
		m0_per = 0;
		last_t = 0;
		m0_got = 8'h00;
	end

	////////////////////////////////////////////////////////////////
	// mode 0: capture device data on each rising shift clock, time the period
	always @(posedge txd_line) if (rxd_oe) begin
		m0_got = {rxd_line, m0_got[7:1]};
		m0_per = int'($realtime - last_t);
		last_t = $realtime;
	end

	// mode 0: present the next bit on each falling shift clock
	always @(negedge txd_line) if (m0_arm && !rxd_oe && m0_i < 8) begin
		p_drv = 1'b1;
		p_val = m0_tx[m0_i];
		m0_i++;
	end

	// release after the last rising edge once hold has passed; pull-up takes the line
	always @(posedge txd_line) if (m0_arm && m0_i == 8) begin
		#300;
		p_drv = 1'b0;
		m0_arm = 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// mode 1: one frame, start, eight data low bit first, stop
	task automatic send(input logic [7:0] d, input logic stp);
		int i;
		p_drv = 1'b1;
		p_val = 1'b0;
		#(BIT_NS);
		for (i = 0; i < 8; i++) begin
			p_val = d[i];
			#(BIT_NS);
		end
		p_val = stp;
		#(BIT_NS);
		p_drv = 1'b0;
	endtask

	// mode 1: decode one frame from the device, sampling mid-bit
	task automatic recv(output logic [7:0] d, output logic stp);
		int i;
		@(negedge txd_line);
		#(BIT_NS / 2);
		for (i = 0; i < 8; i++) begin
			#(BIT_NS);
			d[i] = txd_line;
		end
		#(BIT_NS);
		stp = txd_line;
	endtask

	// short low pulse, too short to be a start bit, then idle for a bit time
	task automatic glitch();
		p_drv = 1'b1;
		p_val = 1'b0;
		#150;
		p_drv = 1'b0;
		#(BIT_NS);
	endtask
endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top;
	import usm_pkg::*;

	typedef struct {logic [2:0] a; logic w; logic [15:0] d; logic [15:0] e;} usm_row_s;

	logic              clk_sys;
	logic              resetn;
	logic              reg_wr;
	logic              reg_rd;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic [DATA_W-1:0] reg_rdata;
	logic [DATA_W-1:0] v;
	logic              txd_out;
	logic              txd_oe;
	logic              rxd_out;
	logic              rxd_oe;
	logic              p_drv;
	logic              p_val;
	logic              stp;
	logic [7:0]        got;
	int                err_count;
	int                comparisons;
	int                cycles;
	// pins with pull-ups, resolved from every driver
	wire               txd_line = txd_oe ? txd_out : 1'b1;
	wire               rxd_line = rxd_oe ? rxd_out : (p_drv ? p_val : 1'b1);

	usm_row_s rows[7] = '{'{REG_CTRL, 0, 16'h0000, 16'h0000}, '{REG_PORT, 0, 16'h0000, 16'h000c},
		'{REG_PHASE, 0, 16'h0000, 16'h0000}, '{3'h5, 0, 16'h0000, 16'h0000},
		'{REG_PHASE, 1, 16'h1234, 16'h1234}, '{3'h7, 1, 16'hffff, 16'h0000},
		'{REG_PORT, 1, 16'h000c, 16'h000c}};

	usm_uart DUT (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.txd_out, .txd_oe, .rxd_in(rxd_line), .rxd_out, .rxd_oe);

	usm_partner PTR (.txd_line, .rxd_line, .rxd_oe, .p_drv, .p_val);

	////////////////////////////////////////////////////////////////
	// clock and hang guard
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 30000) begin
			err_count++;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////
	// register bus cycles
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// poll the control register until a flag sets, bounded
	task automatic wait_bit(input int b);
		int k;
		v = '0;
		for (k = 0; k < 3000 && v[b] !== 1'b1; k++) rd(REG_CTRL, v);
		`CHK("flag", 1'b1, v[b])
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		resetn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		#1 `CHK("tx oe idle", 1'b0, txd_oe)
		`CHK("tx idle level", 1'b1, txd_out)
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			rd(rows[i].a, v);
			`CHK("reg", rows[i].e, v)
		end
		$display("test registers done");
		// mode 0 transmit at both shift rates
		for (int s = 0; s < 2; s++) begin
			wr(REG_CTRL, s ? 16'h0020 : 16'h0000);
			wr(REG_DATA, 16'h00a5 ^ 16'(s));
			wait_bit(CTRL_TXDONE);
			`CHK("m0 tx byte", 8'ha5 ^ 8'(s), PTR.m0_got)
			`CHK("m0 period", s ? 200 : 600, PTR.m0_per)
			repeat (4) @(posedge clk_sys);
			`CHK("tx oe after", 1'b0, txd_oe)
		end
		$display("test mode0 transmit done");
		// mode 0 receive: none without enable, then one byte, then blocked
		wr(REG_CTRL, 16'h0000);
		repeat (40) @(posedge clk_sys);
		`CHK("no clock", 1'b0, txd_oe)
		PTR.m0_tx = 8'h3c;
		PTR.m0_i = 0;
		PTR.m0_arm = 1'b1;
		wr(REG_CTRL, 16'h0010);
		wait_bit(CTRL_RXDONE);
		rd(REG_DATA, v);
		`CHK("m0 rx byte", 16'h003c, v)
		repeat (60) @(posedge clk_sys);
		`CHK("rx blocked", 1'b0, txd_oe)
		$display("test mode0 receive done");
		// mode 1 transmit and receive
		wr(REG_PHASE, 16'h8000);
		wr(REG_CTRL, 16'h00d0);
		fork
			PTR.recv(got, stp);
			wr(REG_DATA, 16'h0096);
		join
		`CHK("m1 tx byte", 8'h96, got)
		`CHK("m1 tx stop", 1'b1, stp)
		wait_bit(CTRL_TXDONE);
		PTR.send(8'h5b, 1'b1);
		wait_bit(CTRL_RXDONE);
		`CHK("extra bit", 1'b1, v[CTRL_EXTRA])
		rd(REG_DATA, v);
		`CHK("m1 rx byte", 16'h005b, v)
		PTR.send(8'h11, 1'b1);
		rd(REG_DATA, v);
		`CHK("kept on flag", 16'h005b, v)
		wr(REG_CTRL, 16'h00f0);
		PTR.send(8'h22, 1'b0);
		rd(REG_CTRL, v);
		`CHK("bad stop flag", 1'b0, v[CTRL_RXDONE])
		rd(REG_DATA, v);
		`CHK("bad stop data", 16'h005b, v)
		$display("test mode1 accept and reject done");
		// false start, then both directions at once
		PTR.glitch();
		fork
			PTR.send(8'h44, 1'b1);
			PTR.recv(got, stp);
			wr(REG_DATA, 16'h0069);
		join
		wait_bit(CTRL_RXDONE);
		rd(REG_DATA, v);
		`CHK("after glitch", 16'h0044, v)
		`CHK("duplex tx", 8'h69, got)
		$display("test mode1 duplex done");
		end_of_test();
	end
endmodule
